// ==== test_tsr_top.sv ====
// Purpose: Self-checking bench of the monitor's SMBus and register side.
// Assumes: Short timeout and conversion counts for simulation.
// Notes:   Data wire is the AND of host and device; released means high.
`default_nettype none
`include "tsr_consts.svh"
module test_tsr_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [`TSR_CNT_W-1:0] TO = `TSR_CNT_W'(300);
  localparam logic [`TSR_CNT_W-1:0] MC = `TSR_CNT_W'(50);
  localparam logic [7:0] AW = {`TSR_SLV_ADDR, 1'b0};
  localparam logic [7:0] AR = {`TSR_SLV_ADDR, 1'b1};
  logic        clk, rst_n, scl, sda_m, sda_w, dat_o, dat_oe;
  logic        alert_o, alert_oe, crit_o, crit_oe, d_open, d_short;
  logic [7:0]  ltemp;
  logic [10:0] rtemp;
  logic [8:0]  q;
  int          errors, checks;
  assign sda_w = sda_m & (dat_oe ? dat_o : 1'b1);
  tsr_host u_tsr_host (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  tsr_top #(.TIMEOUT_CYC(TO), .MEAS_CYC(MC)) u_tsr_top (
    .CLK_I(clk), .RST_N_I(rst_n), .SMBCLK_I(scl), .SMBDAT_I(sda_w),
    .SMBDAT_O(dat_o), .SMBDAT_OE_O(dat_oe), .ALERT_N_O(alert_o),
    .ALERT_N_OE_O(alert_oe), .TCRIT_N_O(crit_o), .TCRIT_N_OE_O(crit_oe),
    .LOCAL_TEMP_I(ltemp), .REMOTE_TEMP_I(rtemp), .DIODE_OPEN_I(d_open),
    .DIODE_SHORT_I(d_short));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic ak;
    u_tsr_host.start();
    u_tsr_host.xfer({AW, 1'b1}, q);
    ak = q[0];
    u_tsr_host.xfer({a, 1'b1}, q);
    ak |= q[0];
    u_tsr_host.xfer({d, 1'b1}, q);
    ak |= q[0];
    u_tsr_host.stop();
    chk("write ack", {7'h0, ak}, 8'h00);
  endtask
  task automatic rd_cur(output logic [7:0] d);
    u_tsr_host.start();
    u_tsr_host.xfer({AR, 1'b1}, q);
    u_tsr_host.xfer(9'h1ff, q);
    d = q[8:1];
    u_tsr_host.stop();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    u_tsr_host.start();
    u_tsr_host.xfer({AW, 1'b1}, q);
    u_tsr_host.xfer({a, 1'b1}, q);
    rd_cur(d);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, d, exp);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] ra [9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                           8'h19, 8'h20, 8'hbf};
    logic [7:0] rv [9] = '{8'h00, 8'h08, 8'h46, 8'h00, 8'h46, 8'h00,
                           8'h55, 8'h55, 8'h00};
    wait_cyc(100);
    rd_cur(d);
    chk("pointer at reset", d, 8'h1a);
    foreach (ra[i]) begin
      rd_reg(ra[i], d);
      chk("reset value", d, rv[i]);
    end
    chk_reg("write only", 8'h0f, 8'h00);
  endtask
  task automatic t_regs();
    wr_reg(8'h0b, 8'h22);
    chk_reg("local high", 8'h05, 8'h22);
    u_tsr_host.start();
    u_tsr_host.xfer({AR, 1'b1}, q);
    u_tsr_host.xfer(9'h1fe, q);
    chk("acked read", q[8:1], 8'h22);
    u_tsr_host.xfer(9'h1ff, q);
    chk("second read", q[8:1], 8'h22);
    u_tsr_host.stop();
    chk_reg("write address", 8'h0b, 8'h00);
    wr_reg(8'h00, 8'h55);
    wr_reg(8'h05, 8'h66);
    chk_reg("local high kept", 8'h05, 8'h22);
    chk_reg("local temp kept", 8'h00, 8'h1a);
    wr_reg(8'hbf, 8'hff);
    chk_reg("filter bits", 8'hbf, 8'h07);
    wr_reg(8'hbf, 8'h00);
    u_tsr_host.start();
    u_tsr_host.xfer({AW, 1'b1}, q);
    u_tsr_host.xfer(9'h017, q);
    u_tsr_host.xfer(9'h089, q);
    u_tsr_host.xfer(9'h0ab, q);
    chk("extra byte ack", {7'h0, q[0]}, 8'h01);
    u_tsr_host.stop();
    chk_reg("one data byte", 8'h05, 8'h44);
    u_tsr_host.start();
    u_tsr_host.xfer({AW ^ 8'h02, 1'b1}, q);
    chk("foreign address", {7'h0, q[0]}, 8'h01);
    u_tsr_host.stop();
  endtask
  task automatic t_recover();
    u_tsr_host.start();
    u_tsr_host.xfer({AW, 1'b1}, q);
    wr_reg(8'h0b, 8'h33);
    chk_reg("after restart", 8'h05, 8'h33);
    u_tsr_host.start();
    u_tsr_host.xfer({AW, 1'b1}, q);
    u_tsr_host.xfer(9'h017, q);
    u_tsr_host.hold_low(TO + 50);
    u_tsr_host.xfer(9'h089, q);
    chk("after timeout", {7'h0, q[0]}, 8'h01);
    u_tsr_host.stop();
    chk_reg("no write", 8'h05, 8'h33);
  endtask
  task automatic t_fault();
    logic [7:0] d;
    @(posedge clk);
    d_open <= 1'b1;
    wait_cyc(200);
    chk_reg("open high", 8'h01, 8'h7f);
    chk_reg("open low", 8'h10, 8'h00);
    rd_reg(8'h02, d);
    chk("open flag", {7'h0, d[2]}, 8'h01);
    chk("open alert", {7'h0, alert_oe}, 8'h01);
    chk("open crit", {7'h0, crit_oe}, 8'h01);
    @(posedge clk);
    d_open <= 1'b0;
    d_short <= 1'b1;
    wait_cyc(200);
    chk_reg("short high", 8'h01, 8'h80);
    rd_reg(8'h02, d);
    chk("short flags", {6'h0, d[3:2]}, 8'h02);
    chk("short alert", {7'h0, alert_oe}, 8'h01);
    wr_reg(8'h09, 8'h80);
    wait_cyc(100);
    chk("masked alert", {7'h0, alert_oe}, 8'h00);
    @(posedge clk);
    d_short <= 1'b0;
  endtask
  task automatic t_oneshot();
    logic [7:0] d;
    wr_reg(8'h09, 8'h41);
    wait_cyc(100);
    @(posedge clk);
    rtemp <= 11'h283;
    wait_cyc(200);
    chk_reg("standby hold", 8'h01, 8'h19);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h0f, 8'h5a);
      wait_cyc(100);
      rd_reg(8'h02, d);
      chk("queued high", {7'h0, d[4]}, {7'h0, i == 2});
      chk("idle busy", {7'h0, d[7]}, 8'h00);
    end
    chk("queued alert", {7'h0, alert_oe}, 8'h01);
    chk_reg("shot high", 8'h01, 8'h50);
    chk_reg("shot low", 8'h10, 8'h60);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #900000;
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    ltemp = 8'h1a;
    rtemp = 11'h0cb;
    d_open = 1'b0;
    d_short = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(3);
    t_reset();
    t_regs();
    t_recover();
    t_fault();
    t_oneshot();
    final_report();
  end
endmodule
`default_nettype wire

// ==== tsr_consts.svh ====
// Purpose: Named constants of the temperature monitor SMBus register block.
// Assumes: 100 MHz core clock.
// Notes:   Times are kept in microseconds; cycle counts derive from them.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH
`define TSR_CLK_MHZ      100
`define TSR_CNT_W        22
`define TSR_TIMEOUT_US   35000
`define TSR_TIMEOUT_CYC  (`TSR_TIMEOUT_US * `TSR_CLK_MHZ)
`define TSR_MEAS_US      31250
`define TSR_MEAS_CYC     (`TSR_MEAS_US * `TSR_CLK_MHZ)
`define TSR_SLV_ADDR     7'h4c
`define TSR_RA_LTEMP     8'h00
`define TSR_RA_RTEMP_HI  8'h01
`define TSR_RA_STATUS    8'h02
`define TSR_RA_CFG       8'h03
`define TSR_RA_RATE      8'h04
`define TSR_RA_LHI       8'h05
`define TSR_RA_LLO       8'h06
`define TSR_RA_RHI       8'h07
`define TSR_RA_RLO       8'h08
`define TSR_RA_RTEMP_LO  8'h10
`define TSR_WA_CFG       8'h09
`define TSR_WA_RATE      8'h0a
`define TSR_WA_LHI       8'h0b
`define TSR_WA_LLO       8'h0c
`define TSR_WA_RHI       8'h0d
`define TSR_WA_RLO       8'h0e
`define TSR_WA_ONESHOT   8'h0f
`define TSR_RW_RCRIT     8'h19
`define TSR_RW_LCRIT     8'h20
`define TSR_RW_FILT      8'hbf
`define TSR_RST_PTR      8'h00
`define TSR_RST_CFG      8'h00
`define TSR_RST_RATE     8'h08
`define TSR_RST_HI       8'h46
`define TSR_RST_LO       8'h00
`define TSR_RST_CRIT     8'h55
`define TSR_RST_FILT     8'h00
`define TSR_CFG_WMASK    8'hd5
`define TSR_FILT_WMASK   8'h07
`define TSR_CFG_AMASK    7
`define TSR_CFG_STOP     6
`define TSR_CFG_RCMASK   4
`define TSR_CFG_LCMASK   2
`define TSR_CFG_FQ       0
`define TSR_FILT_MSB     2
`define TSR_FILT_LSB     1
`define TSR_FILT_OFF     2'h0
`define TSR_FILT_L2      2'h3
`define TSR_OPEN_CODE    8'h7f
`define TSR_SHORT_CODE   8'h80
`define TSR_FQ_DEPTH     2'h3
`define TSR_LAST_BIT     3'h7
`endif

// ==== tsr_host.sv ====
// Purpose: SMBus host that clocks frames into the monitor.
// Assumes: Bits of 125 nanoseconds; bench clock edges at 5 past each 10.
// Notes:   The clock stands high between frames, as a real host leaves it.
`default_nettype none
module tsr_host (
  // Bus pins
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    real ph;
    // Frames start 1 after a clock edge so no line moves on a sampling edge.
    ph = 16.0 - ($realtime - 10.0 * $floor($realtime / 10.0));
    if (ph >= 10.0) begin
      ph = ph - 10.0;
    end
    #(ph) scl_o = 1'b0;
    #40 sda_o = 1'b1;
    #30 scl_o = 1'b1;
    #60 sda_o = 1'b0;
    #60 scl_o = 1'b0;
  endtask
  task automatic stop();
    #40 sda_o = 1'b0;
    #30 scl_o = 1'b1;
    #60 sda_o = 1'b1;
    #60;
  endtask
  // Nine bits: eight sent MSB first, then the acknowledge slot.
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #31.2 sda_o = d[i];
      #31.3 scl_o = 1'b1;
      #31.2 q[i] = sda_i;
      #31.3 scl_o = 1'b0;
    end
  endtask
  task automatic hold_low(input int n);
    #(n * 10);
  endtask
endmodule
`default_nettype wire

// ==== tsr_pkg.sv ====
// Purpose: Types shared by the temperature monitor register block.
// Assumes: Widths follow tsr_consts.svh.
// Notes:   State structs hold all flip-flops of each module.
`default_nettype none
`include "tsr_consts.svh"
package tsr_pkg;
  typedef enum logic [3:0] {
    SMB_IDLE = 4'h0,
    SMB_ADDR = 4'h1,
    SMB_AACK = 4'h3,
    SMB_CMD  = 4'h2,
    SMB_CACK = 4'h6,
    SMB_WDAT = 4'h7,
    SMB_WACK = 4'h5,
    SMB_DONE = 4'h4,
    SMB_RDAT = 4'hb,
    SMB_RACK = 4'ha
  } tsr_smb_t;
  typedef struct packed {
    logic [12:0] acc;
    logic [7:0]  temp_hi;
    logic [7:0]  temp_lo;
    logic        open_flag;
    logic [5:0]  fq_cnt;
    logic [2:0]  flags;
  } tsr_rch_st_t;
endpackage
`default_nettype wire

// ==== tsr_rch.sv ====
// Purpose: Remote channel: fault codes, digital filter, limits, fault queue.
// Assumes: sample is a one-cycle strobe with raw and fault inputs valid.
// Notes:   The filter keeps two extra fraction bits to limit drift.
`default_nettype none
`include "tsr_consts.svh"
module tsr_rch (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Channel link
  tsr_rch_if.rch   ch
);
  import tsr_pkg::*;
  tsr_rch_st_t st;
  tsr_rch_st_t n;
  logic [14:0] s1;
  logic [14:0] s2;
  logic [10:0] v;
  logic [2:0]  c;
  logic [1:0]  q;

  always_comb begin
    n  = st;
    s1 = {{2{st.acc[12]}}, st.acc} + {{2{ch.raw[10]}}, ch.raw, 2'h0};
    s2 = s1 + {{2{st.acc[12]}}, st.acc} + {{2{st.acc[12]}}, st.acc};
    v  = {st.temp_hi, st.temp_lo[7:5]};
    c  = 3'h0;
    q  = 2'h0;
    if (ch.sample) begin
      if (ch.open_f) begin
        n.temp_hi   = `TSR_OPEN_CODE; // R2
        n.temp_lo   = 8'h00; // R2
        n.open_flag = 1'b1; // R2
      end else if (ch.short_f) begin
        n.temp_hi   = `TSR_SHORT_CODE; // R5
        n.temp_lo   = 8'h00;
        n.open_flag = 1'b0; // R5
      end else begin
        n.open_flag = 1'b0;
        unique case (ch.filt) // R18
          `TSR_FILT_OFF: n.acc = {ch.raw, 2'h0};
          `TSR_FILT_L2:  n.acc = s2[14:2];
          default:       n.acc = s1[13:1];
        endcase
        n.temp_hi = n.acc[12:5];
        n.temp_lo = {n.acc[4:2], 5'h00};
      end
      // A fault code also seeds the filter so recovery starts from it.
      if (ch.open_f || ch.short_f) begin
        n.acc = {n.temp_hi, 5'h00};
      end
      v = {n.temp_hi, n.temp_lo[7:5]};
      // The open flag takes no part here; only the reading is compared.
      c[0] = $signed(v) > $signed({ch.lim_hi, 3'h0}); // R3 R4
      c[1] = $signed(v) < $signed({ch.lim_lo, 3'h0}); // R6
      c[2] = $signed(v) > $signed({ch.lim_crit, 3'h0}); // R3
      for (int i = 0; i < 3; i++) begin
        q = st.fq_cnt[2*i +: 2];
        if (!c[i]) begin
          q = 2'h0;
        end else if (q != `TSR_FQ_DEPTH) begin
          q = q + 2'h1;
        end
        n.fq_cnt[2*i +: 2] = q;
        n.flags[i] = ch.fq_en ? (q == `TSR_FQ_DEPTH) : c[i]; // R19
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign ch.temp_hi   = st.temp_hi;
  assign ch.temp_lo   = st.temp_lo;
  assign ch.open_flag = st.open_flag;
  assign ch.flags     = st.flags;
endmodule
`default_nettype wire

// ==== tsr_rch_if.sv ====
// Purpose: Carries samples, settings and results to the remote channel.
// Assumes: One clock for both ends.
// Notes:   flags holds high, low and critical in bits 0, 1 and 2.
`default_nettype none
interface tsr_rch_if;
  logic        sample;
  logic [10:0] raw;
  logic        open_f;
  logic        short_f;
  logic [1:0]  filt;
  logic        fq_en;
  logic [7:0]  lim_hi;
  logic [7:0]  lim_lo;
  logic [7:0]  lim_crit;
  logic [7:0]  temp_hi;
  logic [7:0]  temp_lo;
  logic        open_flag;
  logic [2:0]  flags;
  modport src (output sample, raw, open_f, short_f, filt, fq_en, lim_hi,
               lim_lo, lim_crit, input temp_hi, temp_lo, open_flag, flags);
  modport rch (input sample, raw, open_f, short_f, filt, fq_en, lim_hi,
               lim_lo, lim_crit, output temp_hi, temp_lo, open_flag, flags);
endinterface
`default_nettype wire

// ==== tsr_top.sv ====
// Purpose: SMBus slave and register file of a local and remote monitor.
// Assumes: Converter results share CLK_I; SMBus pins are asynchronous.
// Notes:   Pins are open drain: drive low while the enable is high.
//
// Overview of operation
// R1 - Data, alarm and critical pins only pull low or release, never high.
// R2 - Open or supply-shorted diode: high byte 127, low byte 0, open flag.
// R3 - Substituted reading is compared normally; may raise both alarms.
// R4 - Open flag alone never drives the alarm output.
// R5 - Diode shorted to ground: high byte reads minus 128, flag stays clear.
// R6 - Reading below remote low limit drives alarm unless masked.
// R7 - Pointer selects register, resets to local temperature, holds value.
// R8 - Locations are read only, write only, or read/write on one or two.
// R9 - Write is address, command byte into pointer, one data byte stored.
// R10 - Plain read returns byte at the latched pointer.
// R11 - Read with pointer change uses command byte and repeated start.
// R12 - Bytes go out MSB first; master ack or nack both end cleanly.
// R13 - One measurement cycle of both sensors takes 31.25 ms.
// R14 - Master reads both remote bytes from one conversion; the code keeps no copy, each byte reads the latest result.
// R15 - Clock or data low beyond 35 ms returns slave to idle.
// R16 - Master forces bus recovery by holding a line low 35 ms.
// R17 - A start anywhere abandons the transfer and expects an address.
// R18 - Filter strength from filter register bits two and one.
// R19 - Fault queue needs three out-of-limit remote samples when enabled.
// R20 - Write to the one-shot location starts one conversion cycle.
// R21 - Writes to unwritable or undefined locations are acked, no effect.
// R22 - Fixed seven-bit address; clock never driven or stretched.
// R23 - Configuration bit seven masks the alarm output.
// R24 - Status bit seven shows busy; bit two shows open diode.
`default_nettype none
`include "tsr_consts.svh"
module tsr_top #(
  parameter logic [`TSR_CNT_W-1:0] TIMEOUT_CYC =
    `TSR_CNT_W'(`TSR_TIMEOUT_CYC),
  parameter logic [`TSR_CNT_W-1:0] MEAS_CYC =
    `TSR_CNT_W'(`TSR_MEAS_CYC)
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // SMBus pins
  input  wire logic        SMBCLK_I,
  input  wire logic        SMBDAT_I,
  output var  logic        SMBDAT_O,
  output var  logic        SMBDAT_OE_O,
  // Alarm pins
  output var  logic        ALERT_N_O,
  output var  logic        ALERT_N_OE_O,
  output var  logic        TCRIT_N_O,
  output var  logic        TCRIT_N_OE_O,
  // Converter results
  input  wire logic [7:0]  LOCAL_TEMP_I,
  input  wire logic [10:0] REMOTE_TEMP_I,
  input  wire logic        DIODE_OPEN_I,
  input  wire logic        DIODE_SHORT_I
);
  import tsr_pkg::*;

  typedef struct packed {
    logic                  scl_m;
    logic                  scl_s;
    logic                  scl_d;
    logic                  sda_m;
    logic                  sda_s;
    logic                  sda_d;
    tsr_smb_t              fsm;
    logic [2:0]            bitc;
    logic                  byte_done;
    logic [7:0]            sh;
    logic                  rw;
    logic                  mack;
    logic                  sda_oe;
    logic [`TSR_CNT_W-1:0] tocnt;
    logic [7:0]            ptr;
    logic [7:0]            cfg;
    logic [7:0]            rate;
    logic [7:0]            lhi;
    logic [7:0]            llo;
    logic [7:0]            rhi;
    logic [7:0]            rlo;
    logic [7:0]            rcrit;
    logic [7:0]            lcrit;
    logic [7:0]            filt;
    logic [7:0]            ltemp;
    logic                  lhi_f;
    logic                  llo_f;
    logic                  lcrit_f;
    logic                  busy;
    logic                  oneshot;
    logic [`TSR_CNT_W-1:0] mcnt;
    logic                  sample;
    logic                  alert_oe;
    logic                  tcrit_oe;
    logic                  od_lvl;
  } tsr_st_t;

  tsr_st_t   st;
  tsr_st_t   n;
  tsr_rch_if rch_l ();

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] status;

  assign status = {st.busy, st.lhi_f, st.llo_f, rch_l.flags[0],
                   rch_l.flags[1], rch_l.open_flag, rch_l.flags[2],
                   st.lcrit_f}; // R24

  // Read decode: write-only and undefined locations read as zero.
  always_comb begin
    unique case (st.ptr) // R8
      `TSR_RA_LTEMP:    rd_data = st.ltemp;
      `TSR_RA_RTEMP_HI: rd_data = rch_l.temp_hi;
      `TSR_RA_STATUS:   rd_data = status;
      `TSR_RA_CFG:      rd_data = st.cfg;
      `TSR_RA_RATE:     rd_data = st.rate;
      `TSR_RA_LHI:      rd_data = st.lhi;
      `TSR_RA_LLO:      rd_data = st.llo;
      `TSR_RA_RHI:      rd_data = st.rhi;
      `TSR_RA_RLO:      rd_data = st.rlo;
      `TSR_RA_RTEMP_LO: rd_data = rch_l.temp_lo;
      `TSR_RW_RCRIT:    rd_data = st.rcrit;
      `TSR_RW_LCRIT:    rd_data = st.lcrit;
      `TSR_RW_FILT:     rd_data = st.filt;
      default:          rd_data = 8'h00;
    endcase
  end

  always_comb begin
    n       = st;
    wr_en   = 1'b0;
    wr_addr = st.ptr;
    wr_data = st.sh;
    n.sample = 1'b0;
    // The first stage of each synchroniser is never looked at; edges compare the second and third.
    n.scl_m = SMBCLK_I;
    n.scl_s = st.scl_m;
    n.scl_d = st.scl_s;
    n.sda_m = SMBDAT_I;
    n.sda_s = st.sda_m;
    n.sda_d = st.sda_s;
    scl_rise = st.scl_s & ~st.scl_d;
    scl_fall = ~st.scl_s & st.scl_d;
    start_c  = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
    stop_c   = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;

    unique case (st.fsm)
      SMB_IDLE, SMB_DONE: begin
      end
      SMB_ADDR, SMB_CMD, SMB_WDAT: begin
        if (scl_rise) begin
          n.sh   = {st.sh[6:0], st.sda_s};
          n.bitc = st.bitc + 3'h1;
          if (st.bitc == `TSR_LAST_BIT) begin
            n.byte_done = 1'b1;
          end
        end else if (scl_fall && st.byte_done) begin
          n.byte_done = 1'b0;
          n.sda_oe    = 1'b1;
          if (st.fsm == SMB_ADDR) begin
            if (st.sh[7:1] == `TSR_SLV_ADDR) begin // R22
              n.fsm = SMB_AACK;
              n.rw  = st.sh[0];
            end else begin
              n.fsm    = SMB_IDLE;
              n.sda_oe = 1'b0;
            end
          end else if (st.fsm == SMB_CMD) begin
            n.ptr = st.sh; // R7 R9
            n.fsm = SMB_CACK;
          end else begin
            wr_en = 1'b1; // R9
            n.fsm = SMB_WACK;
          end
        end
      end
      SMB_AACK: begin
        if (scl_fall) begin
          if (st.rw) begin
            n.fsm    = SMB_RDAT; // R10 R11
            n.sh     = rd_data;
            n.sda_oe = ~rd_data[7]; // R12
          end else begin
            n.fsm    = SMB_CMD;
            n.sda_oe = 1'b0;
          end
        end
      end
      SMB_CACK: begin
        if (scl_fall) begin
          n.fsm    = SMB_WDAT;
          n.sda_oe = 1'b0;
        end
      end
      SMB_WACK: begin
        // Further data bytes are not acknowledged.
        if (scl_fall) begin
          n.fsm    = SMB_DONE; // R9
          n.sda_oe = 1'b0;
        end
      end
      SMB_RDAT: begin
        if (scl_rise) begin
          n.bitc = st.bitc + 3'h1;
          if (st.bitc == `TSR_LAST_BIT) begin
            n.byte_done = 1'b1;
          end
        end else if (scl_fall) begin
          if (st.byte_done) begin
            n.byte_done = 1'b0;
            n.sda_oe    = 1'b0;
            n.fsm       = SMB_RACK;
          end else begin
            n.sh     = {st.sh[6:0], 1'b0};
            n.sda_oe = ~st.sh[6]; // R12
          end
        end
      end
      SMB_RACK: begin
        if (scl_rise) begin
          n.mack = ~st.sda_s;
        end else if (scl_fall) begin
          if (st.mack) begin
            // Acked: the same location is sent again.
            n.fsm    = SMB_RDAT;
            n.sh     = rd_data;
            n.sda_oe = ~rd_data[7];
          end else begin
            n.fsm = SMB_DONE; // R12
          end
        end
      end
      default: begin
        n.fsm    = SMB_IDLE;
        n.sda_oe = 1'b0;
      end
    endcase

    if (start_c) begin
      n.fsm       = SMB_ADDR; // R17
      n.bitc      = 3'h0;
      n.byte_done = 1'b0;
      n.sda_oe    = 1'b0;
    end else if (stop_c) begin
      n.fsm    = SMB_IDLE;
      n.sda_oe = 1'b0;
    end

    // Either line low counts; the bus timeout overrides the bus state, start and stop.
    if (!st.scl_s || !st.sda_s) begin
      n.tocnt = st.tocnt + `TSR_CNT_W'(1);
      if (st.tocnt == TIMEOUT_CYC) begin
        n.tocnt  = '0;
        n.fsm    = SMB_IDLE; // R15
        n.sda_oe = 1'b0;
      end
    end else begin
      n.tocnt = '0;
    end

    // Conversion sequencer: runs back to back unless stopped.
    if (!st.busy) begin
      if (!st.cfg[`TSR_CFG_STOP] || st.oneshot) begin
        n.busy    = 1'b1; // R24
        n.oneshot = 1'b0;
        n.mcnt    = '0;
      end
    end else if (st.mcnt == MEAS_CYC - `TSR_CNT_W'(1)) begin
      n.busy    = 1'b0; // R13
      n.sample  = 1'b1;
      n.ltemp   = LOCAL_TEMP_I;
      n.lhi_f   = $signed(LOCAL_TEMP_I) > $signed(st.lhi);
      n.llo_f   = $signed(LOCAL_TEMP_I) < $signed(st.llo);
      n.lcrit_f = $signed(LOCAL_TEMP_I) > $signed(st.lcrit);
    end else begin
      n.mcnt = st.mcnt + `TSR_CNT_W'(1);
    end

    // Writes come last so a one-shot request beats the sequencer clear.
    if (wr_en) begin
      unique case (wr_addr) // R8
        `TSR_WA_CFG:     n.cfg   = wr_data & `TSR_CFG_WMASK;
        `TSR_WA_RATE:    n.rate  = wr_data;
        `TSR_WA_LHI:     n.lhi   = wr_data;
        `TSR_WA_LLO:     n.llo   = wr_data;
        `TSR_WA_RHI:     n.rhi   = wr_data;
        `TSR_WA_RLO:     n.rlo   = wr_data;
        `TSR_RW_RCRIT:   n.rcrit = wr_data;
        `TSR_RW_LCRIT:   n.lcrit = wr_data;
        `TSR_RW_FILT:    n.filt  = wr_data & `TSR_FILT_WMASK;
        `TSR_WA_ONESHOT: n.oneshot = 1'b1; // R20
        default: begin
        end // R21
      endcase
    end

    // The open flag is left out of the alarm terms on purpose.
    n.alert_oe = ~st.cfg[`TSR_CFG_AMASK] &
                 (st.lhi_f | st.llo_f | st.lcrit_f |
                  rch_l.flags[0] | rch_l.flags[1] |
                  rch_l.flags[2]); // R3 R4 R6 R23
    n.tcrit_oe = (st.lcrit_f & ~st.cfg[`TSR_CFG_LCMASK]) |
                 (rch_l.flags[2] & ~st.cfg[`TSR_CFG_RCMASK]); // R3
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st       <= '0;
      st.scl_m <= 1'b1;
      st.scl_s <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_m <= 1'b1;
      st.sda_s <= 1'b1;
      st.sda_d <= 1'b1;
      st.fsm   <= SMB_IDLE;
      st.ptr   <= `TSR_RST_PTR; // R7
      st.cfg   <= `TSR_RST_CFG;
      st.rate  <= `TSR_RST_RATE;
      st.lhi   <= `TSR_RST_HI;
      st.llo   <= `TSR_RST_LO;
      st.rhi   <= `TSR_RST_HI;
      st.rlo   <= `TSR_RST_LO;
      st.rcrit <= `TSR_RST_CRIT;
      st.lcrit <= `TSR_RST_CRIT;
      st.filt  <= `TSR_RST_FILT;
    end else begin
      st <= n;
    end
  end

  assign rch_l.sample   = st.sample;
  assign rch_l.raw      = REMOTE_TEMP_I;
  assign rch_l.open_f   = DIODE_OPEN_I;
  assign rch_l.short_f  = DIODE_SHORT_I;
  assign rch_l.filt     = st.filt[`TSR_FILT_MSB:`TSR_FILT_LSB];
  assign rch_l.fq_en    = st.cfg[`TSR_CFG_FQ];
  assign rch_l.lim_hi   = st.rhi;
  assign rch_l.lim_lo   = st.rlo;
  assign rch_l.lim_crit = st.rcrit;

  tsr_rch u_rch (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .ch      (rch_l)
  );

  // The drive level is a constant low; only the enables ever move.
  assign SMBDAT_O     = st.od_lvl; // R1
  assign SMBDAT_OE_O  = st.sda_oe;
  assign ALERT_N_O    = st.od_lvl;
  assign ALERT_N_OE_O = st.alert_oe;
  assign TCRIT_N_O    = st.od_lvl;
  assign TCRIT_N_OE_O = st.tcrit_oe;
endmodule
`default_nettype wire

// ==== tsr_top_asserts.sv ====
// Purpose: Pin checks of the SMBus slave and the alarm outputs.
// Assumes: Bus bits last about 125 nanoseconds, far beyond the synchronisers.
// Notes:   Bound to tsr_top and sees its ports only.
`default_nettype none
`include "tsr_consts.svh"
module tsr_top_asserts #(
  parameter logic [`TSR_CNT_W-1:0] TIMEOUT_CYC =
    `TSR_CNT_W'(`TSR_TIMEOUT_CYC)
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Bus and alarm pins
  input wire logic SMBCLK_I,
  input wire logic SMBDAT_I,
  input wire logic SMBDAT_O,
  input wire logic SMBDAT_OE_O,
  input wire logic ALERT_N_O,
  input wire logic ALERT_N_OE_O,
  input wire logic TCRIT_N_O,
  input wire logic TCRIT_N_OE_O
);
  logic [`TSR_CNT_W-1:0] low_cnt_r;
  logic [`TSR_CNT_W-1:0] low_cnt_nxt;
  // Either line low keeps counting; a margin covers the synchronisers.
  always_comb begin
    low_cnt_nxt = (SMBCLK_I && SMBDAT_I) ? '0 : low_cnt_r + `TSR_CNT_W'(1);
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_cnt_r <= '0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  pins_low_only_a: assert property (
    !SMBDAT_O && !ALERT_N_O && !TCRIT_N_O)
    else $error("open drain pin driven high");
  reset_quiet_a: assert property (
    $rose(RST_N_I) |-> !SMBDAT_OE_O && !ALERT_N_OE_O && !TCRIT_N_OE_O)
    else $error("pin pulled low right after reset");
  oe_scl_low_a: assert property (
    $changed(SMBDAT_OE_O) |-> !SMBCLK_I)
    else $error("data drive changed while clock high");
  oe_after_fall_a: assert property (
    $rose(SMBDAT_OE_O) |-> !$past(SMBCLK_I, 2))
    else $error("data drive began before clock fell");
  oe_hold_a: assert property (
    $rose(SMBDAT_OE_O) |=> $stable(SMBDAT_OE_O) [*4])
    else $error("data drive not held");
  ack_release_a: assert property (
    $rose(SMBDAT_OE_O) |-> ##[1:300] !SMBDAT_OE_O)
    else $error("data line never released");
  bus_timeout_a: assert property (
    (low_cnt_r > TIMEOUT_CYC + 8) |-> !SMBDAT_OE_O)
    else $error("no return to idle after long low");
  start_release_a: assert property (
    (SMBCLK_I && $past(SMBCLK_I) && $fell(SMBDAT_I)) |-> ##[0:8]
    !SMBDAT_OE_O)
    else $error("start did not release data line");
  stop_idle_a: assert property (
    (SMBCLK_I && $past(SMBCLK_I) && $rose(SMBDAT_I)) |=> !SMBDAT_OE_O [*4])
    else $error("data driven after stop");
endmodule
bind tsr_top tsr_top_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_tsr_top_asserts (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SMBCLK_I(SMBCLK_I),
  .SMBDAT_I(SMBDAT_I), .SMBDAT_O(SMBDAT_O), .SMBDAT_OE_O(SMBDAT_OE_O),
  .ALERT_N_O(ALERT_N_O), .ALERT_N_OE_O(ALERT_N_OE_O),
  .TCRIT_N_O(TCRIT_N_O), .TCRIT_N_OE_O(TCRIT_N_OE_O));
`default_nettype wire
